// ---- bench/tb_up_down_counter_ripple_clock.sv ----
/* Self-checking bench for the up/down counter with ripple clock.
   Assumes the control model drives the clock pin; 3-clock latency. */
`timescale 1ns/1ps
`default_nettype none
module tb_up_down_counter_ripple_clock;
    import udcrc_pkg::*;
    typedef struct packed {
        logic [3:0] pre;
        logic       dir;
        logic       en_n;
        logic [4:0] n;
        logic [3:0] cnt;
        logic       term;
        logic       rip;
    } udcrc_row_t;
    // Preset, direction, enable, pulses -> count, flag, ripple
    udcrc_row_t rows [8] = '{
        '{4'he, 1'b0, 1'b0, 5'h01, 4'hf, 1'b1, 1'b0},
        '{4'hf, 1'b0, 1'b0, 5'h01, 4'h0, 1'b0, 1'b1},
        '{4'h0, 1'b1, 1'b0, 5'h01, 4'hf, 1'b0, 1'b1},
        '{4'h1, 1'b1, 1'b0, 5'h01, 4'h0, 1'b1, 1'b0},
        '{4'h5, 1'b0, 1'b1, 5'h03, 4'h5, 1'b0, 1'b1},
        '{4'h3, 1'b0, 1'b0, 5'h05, 4'h8, 1'b0, 1'b1},
        '{4'hf, 1'b0, 1'b1, 5'h00, 4'hf, 1'b1, 1'b1},
        '{4'ha, 1'b1, 1'b0, 5'h0a, 4'h0, 1'b1, 1'b0}};
    logic       clk_sys_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic       load_n     = 1'b1;
    logic       en_n       = 1'b1;
    logic       dir        = 1'b0;
    logic       start      = 1'b0;
    logic [3:0] pre        = 4'h0;
    logic [4:0] npulse     = 5'h0;
    logic       cp, busy, term, rip_n;
    logic [3:0] cnt, hi_cnt, rc_cnt;
    wire        hi_en_n;
    int         bad_count  = 0;
    int         tests_run  = 0;

    always #25 clk_sys_in = ~clk_sys_in;

    udcrc_counter dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .clock_pulse_in(cp), .async_load_n_in(load_n),
        .count_enable_n_in(en_n), .direction_select_in(dir),
        .preset_data_in(pre), .count_out(cnt),
        .terminal_flag_out(term), .ripple_clock_n_out(rip_n));
    // Parallel gated stage: enable from low flag plus the inhibit
    assign hi_en_n = en_n | ~term;
    udcrc_counter hi_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .clock_pulse_in(cp), .async_load_n_in(load_n),
        .count_enable_n_in(hi_en_n), .direction_select_in(dir),
        .preset_data_in(pre), .count_out(hi_cnt),
        .terminal_flag_out(), .ripple_clock_n_out());
    // Ripple stage: clocked by the low stage's ripple clock
    udcrc_counter rc_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .clock_pulse_in(rip_n), .async_load_n_in(load_n),
        .count_enable_n_in(en_n), .direction_select_in(dir),
        .preset_data_in(pre), .count_out(rc_cnt),
        .terminal_flag_out(), .ripple_clock_n_out());
    udcrc_ctl_model ctl_u (.clk_in(clk_sys_in), .start_in(start),
        .pulses_in(npulse), .clock_pulse_out(cp), .busy_out(busy));

    task automatic chk(input string what, input logic [3:0] exp,
                       input logic [3:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask

    // Bounded wait for the burst, then room for the 3-clock latency
    task automatic pulses(input logic [4:0] n);
        int i;
        npulse <= n;
        start  <= 1'b1;
        tick(1);
        start  <= 1'b0;
        tick(1);
        for (i = 0; i < 300 && busy; i++)
            tick(1);
        tick(5);
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog: the whole run needs about 370 clocks
    initial
    begin
        repeat (6000) @(posedge clk_sys_in);
        bad_count++;
        give_verdict();
    end

    initial
    begin
        tick(2);
        sys_rst_in <= 1'b0;
        tick(1);
        chk("reset count", UDCRC_CNT_RST, cnt);
        chk("reset ripple", {3'h0, UDCRC_RIPN_RST}, {3'h0, rip_n});
        $display("Test reset done");
        foreach (rows[i])
        begin
            pre    <= rows[i].pre;
            dir    <= rows[i].dir;
            en_n   <= rows[i].en_n;
            load_n <= 1'b0;
            tick(5);
            chk("preset count", rows[i].pre, cnt);
            chk("preset ripple", 4'h1, {3'h0, rip_n});
            load_n <= 1'b1;
            tick(4);
            pulses(rows[i].n);
            chk("count", rows[i].cnt, cnt);
            chk("terminal", {3'h0, rows[i].term}, {3'h0, term});
            chk("ripple", {3'h0, rows[i].rip}, {3'h0, rip_n});
            $display("Test row %0d done", i);
        end
        // Direction flip alone must drop the flag and return the ripple clock high
        dir <= UDCRC_DIR_UP;
        tick(5);
        chk("flip flag", 4'h0, {3'h0, term});
        chk("flip ripple", 4'h1, {3'h0, rip_n});
        $display("Test direction flip done");
        // Load held through a burst beats counting
        pre    <= 4'h7;
        load_n <= 1'b0;
        pulses(5'h03);
        chk("load over count", 4'h7, cnt);
        $display("Test load override done");
        // Cascades: high stages step only when the low stage wraps
        pre    <= 4'he;
        dir    <= UDCRC_DIR_UP;
        en_n   <= 1'b0;
        tick(5);
        load_n <= 1'b1;
        tick(4);
        pulses(5'h02);
        chk("cascade low", 4'h0, cnt);
        chk("gated high", 4'hf, hi_cnt);
        chk("ripple high", 4'hf, rc_cnt);
        $display("Test cascade done");
        // Second reset in mid-run
        sys_rst_in <= 1'b1;
        tick(2);
        sys_rst_in <= 1'b0;
        tick(1);
        chk("rerun count", UDCRC_CNT_RST, cnt);
        $display("Test second reset done");
        give_verdict();
    end
endmodule
`default_nettype wire

// ---- bench/udcrc_ctl_model.sv ----
/* Model of the controlling logic that pulses the counter clock pin.
   Assumes the bench system clock; each pulse is 4 clocks high, 4 low. */
`timescale 1ns/1ps
`default_nettype none
module udcrc_ctl_model
(
    input  wire logic       clk_in,
    input  wire logic       start_in,
    input  wire logic [4:0] pulses_in,
    output logic            clock_pulse_out,
    output logic            busy_out
);
    logic [2:0] phase = 3'h0;
    logic [4:0] left  = 5'h0;

    // Pin low between bursts, so the last low phase stays open
    assign busy_out        = (left != 5'h0);
    assign clock_pulse_out = busy_out && !phase[2];

    // Falling edge only, well away from the sampling edge
    always @(negedge clk_in)
    begin
        if (!busy_out && start_in)
            left <= pulses_in;
        else if (busy_out)
        begin
            phase <= phase + 3'h1;
            if (phase == 3'h7)
                left <= left - 5'h1;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/udcrc_counter.sv ----
/*
 * Four-bit up/down counter with preset, terminal flag and ripple
 * clock, rebuilt as synchronous logic on the system clock.
 * Assumes every pin input is asynchronous to clk_sys_in and is slow
 * enough (several system clocks per level) to be sampled reliably.
 */
`timescale 1ns/1ps
`default_nettype none

module udcrc_counter
    import udcrc_pkg::*;
(
    input  wire logic                   clk_sys_in,
    input  wire logic                   sys_rst_in,
    input  wire logic                   clock_pulse_in,
    input  wire logic                   async_load_n_in,
    input  wire logic                   count_enable_n_in,
    input  wire logic                   direction_select_in,
    input  wire logic [UDCRC_CNT_W-1:0] preset_data_in,
    output var  logic [UDCRC_CNT_W-1:0] count_out,
    output var  logic                   terminal_flag_out,
    output var  logic                   ripple_clock_n_out
);

    // Two-stage synchronisers; stage one is read only by stage two
    udcrc_pins_t pins_meta;
    udcrc_pins_t pins;
    logic        clk_prev;
    logic        dir_q;

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            pins_meta <= UDCRC_PINS_RST;
            pins      <= UDCRC_PINS_RST;
            clk_prev  <= UDCRC_PINS_RST.clk_lvl;
        end
        else
        begin
            pins_meta <= '{
                clk_lvl:  clock_pulse_in,
                load_n:   async_load_n_in,
                enable_n: count_enable_n_in,
                dir:      direction_select_in,
                preset:   preset_data_in
            };
            pins      <= pins_meta;
            clk_prev  <= pins.clk_lvl;
        end
    end

    // Decode of the sampled pin group
    wire logic                   clk_rise;
    wire logic                   loading;
    wire logic                   counting;
    wire logic [UDCRC_CNT_W-1:0] count_inc;
    wire logic [UDCRC_CNT_W-1:0] count_dec;
    wire logic [UDCRC_CNT_W-1:0] count_step;

    assign clk_rise   = pins.clk_lvl & ~clk_prev;
    assign loading    = ~pins.load_n;
    assign counting   = pins.load_n & ~pins.enable_n & clk_rise;
    // Natural 4-bit overflow gives the modulo-16 wrap
    assign count_inc  = count_out + UDCRC_CNT_ONE;
    assign count_dec  = count_out - UDCRC_CNT_ONE;
    assign count_step = (pins.dir == UDCRC_DIR_DOWN) ? count_dec
                                                     : count_inc;

    // Next count: load beats counting, otherwise hold
    wire logic [UDCRC_CNT_W-1:0] next_count;
    assign next_count = loading  ? pins.preset :
                        counting ? count_step  :
                                   count_out;

    // Terminal decode from next state and direction, enable unused
    wire logic next_term;
    assign next_term =
        ((next_count == UDCRC_CNT_MAX) && (pins.dir == UDCRC_DIR_UP)) ||
        ((next_count == UDCRC_CNT_MIN) && (pins.dir == UDCRC_DIR_DOWN));

    // Ripple clock low only in the sampled clock low phase
    wire logic next_ripple_n;
    assign next_ripple_n = ~(pins.load_n & ~pins.enable_n & next_term
                             & ~pins.clk_lvl);

    // Output registers; flag from flops so no decode spikes escape
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            count_out          <= UDCRC_CNT_RST;
            terminal_flag_out  <= UDCRC_TERM_RST;
            ripple_clock_n_out <= UDCRC_RIPN_RST;
            dir_q              <= UDCRC_DIR_RST;
        end
        else
        begin
            count_out          <= next_count;
            terminal_flag_out  <= next_term;
            ripple_clock_n_out <= next_ripple_n;
            dir_q              <= pins.dir;
        end
    end

    // Checks on the design's own state
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_count_up;
        counting && (pins.dir == UDCRC_DIR_UP);
    endsequence

    sequence s_count_down;
        counting && (pins.dir == UDCRC_DIR_DOWN);
    endsequence

    sequence s_ripple_armed;
        pins.load_n && !pins.enable_n && next_term && !pins.clk_lvl;
    endsequence

    load_copy_a: assert property (
        loading |=> (count_out == $past(pins.preset)))
        else $error("Preset value not loaded into count");

    hold_count_a: assert property (
        (pins.load_n && pins.enable_n) |=> $stable(count_out))
        else $error("Count moved while disabled");

    edge_only_a: assert property (
        (pins.load_n && !clk_rise) |=> $stable(count_out))
        else $error("Count moved without a clock rising edge");

    count_up_a: assert property (
        s_count_up |=> (count_out == $past(count_out) + UDCRC_CNT_ONE))
        else $error("Up count did not increment");

    count_down_a: assert property (
        s_count_down |=> (count_out == $past(count_out) - UDCRC_CNT_ONE))
        else $error("Down count did not decrement");

    wrap_up_a: assert property (
        (s_count_up and (count_out == UDCRC_CNT_MAX))
            |=> (count_out == UDCRC_CNT_MIN))
        else $error("Up count did not wrap to zero");

    wrap_down_a: assert property (
        (s_count_down and (count_out == UDCRC_CNT_MIN))
            |=> (count_out == UDCRC_CNT_MAX))
        else $error("Down count did not wrap to fifteen");

    term_decode_a: assert property (
        terminal_flag_out ==
            (((count_out == UDCRC_CNT_MAX) && (dir_q == UDCRC_DIR_UP)) ||
             ((count_out == UDCRC_CNT_MIN) && (dir_q == UDCRC_DIR_DOWN))))
        else $error("Terminal flag does not match count and direction");

    term_held_a: assert property (
        (terminal_flag_out && $stable(count_out) && $stable(dir_q))
            |-> $past(terminal_flag_out))
        else $error("Terminal flag rose without a state change");

    term_no_enable_a: assert property (
        (pins.enable_n && pins.load_n && !clk_rise
            && (count_out == UDCRC_CNT_MAX) && (pins.dir == UDCRC_DIR_UP))
            |=> terminal_flag_out)
        else $error("Terminal flag suppressed by disabled enable");

    ripple_low_a: assert property (
        s_ripple_armed |=> !ripple_clock_n_out)
        else $error("Ripple clock did not go low when armed");

    ripple_end_a: assert property (
        (!ripple_clock_n_out ##0 pins.clk_lvl) |=> ripple_clock_n_out)
        else $error("Ripple clock stayed low past the clock rise");

    ripple_force_a: assert property (
        (!pins.load_n || pins.enable_n || !next_term)
            |=> ripple_clock_n_out)
        else $error("Ripple clock low while it must be forced high");

    ripple_term_a: assert property (
        !ripple_clock_n_out |-> terminal_flag_out)
        else $error("Ripple clock low without terminal flag");

    // Preset behaviour beyond the plain copy
    load_over_count_a: assert property (
        (loading && clk_rise && !pins.enable_n)
            |=> (count_out == $past(pins.preset)))
        else $error("Counting beat the preset");

    load_ripple_high_a: assert property (
        loading |=> ripple_clock_n_out)
        else $error("Ripple clock low during preset");

    load_term_up_a: assert property (
        (loading && (pins.preset == UDCRC_CNT_MAX)
            && (pins.dir == UDCRC_DIR_UP)) |=> terminal_flag_out)
        else $error("Preset to fifteen upward left flag low");

    load_term_down_a: assert property (
        (loading && (pins.preset == UDCRC_CNT_MIN)
            && (pins.dir == UDCRC_DIR_DOWN)) |=> terminal_flag_out)
        else $error("Preset to zero downward left flag low");

    // Hold and step checks; a clock edge alone never moves a held count
    hold_edge_a: assert property (
        (pins.load_n && pins.enable_n && clk_rise) |=> $stable(count_out))
        else $error("Disabled count moved on a clock edge");

    hold_two_a: assert property (
        (pins.load_n && pins.enable_n) [*2]
            |=> (count_out == $past(count_out, 2)))
        else $error("Disabled count drifted over two cycles");

    rise_moves_a: assert property (
        counting |=> !$stable(count_out))
        else $error("Enabled clock edge did not move the count");

    // Terminal flag set and cleared by counting or direction
    up_term_set_a: assert property (
        (s_count_up and (count_out == UDCRC_CNT_MAX - UDCRC_CNT_ONE))
            |=> terminal_flag_out)
        else $error("Flag not set on reaching fifteen upward");

    down_term_set_a: assert property (
        (s_count_down and (count_out == UDCRC_CNT_MIN + UDCRC_CNT_ONE))
            |=> terminal_flag_out)
        else $error("Flag not set on reaching zero downward");

    term_mid_low_a: assert property (
        ((count_out != UDCRC_CNT_MAX) && (count_out != UDCRC_CNT_MIN))
            |-> !terminal_flag_out)
        else $error("Flag high away from the end values");

    up_term_clear_a: assert property (
        (s_count_up and (count_out == UDCRC_CNT_MAX))
            |=> !terminal_flag_out)
        else $error("Flag stayed high after upward wrap");

    down_term_clear_a: assert property (
        (s_count_down and (count_out == UDCRC_CNT_MIN))
            |=> !terminal_flag_out)
        else $error("Flag stayed high after downward wrap");

    dir_flip_clear_a: assert property (
        (terminal_flag_out && pins.load_n && !clk_rise
            && (pins.dir != dir_q)) |=> !terminal_flag_out)
        else $error("Flag stayed high after direction change");

    term_enable_free_a: assert property (
        (pins.enable_n && pins.load_n && !clk_rise
            && (count_out == UDCRC_CNT_MIN) && (pins.dir == UDCRC_DIR_DOWN))
            |=> terminal_flag_out)
        else $error("Flag at zero suppressed by disabled enable");

    // Ripple clock edges follow the sampled clock phase
    sequence s_ripple_falls;
        ripple_clock_n_out ##1 !ripple_clock_n_out;
    endsequence

    ripple_clk_high_a: assert property (
        pins.clk_lvl |=> ripple_clock_n_out)
        else $error("Ripple clock low in the clock high phase");

    ripple_fall_a: assert property (
        s_ripple_falls |-> !$past(pins.clk_lvl))
        else $error("Ripple clock fell outside the clock low phase");

    disabled_ripple_a: assert property (
        pins.enable_n |=> ripple_clock_n_out)
        else $error("Ripple clock low while disabled");

    ripple_enable_a: assert property (
        !ripple_clock_n_out |-> $past(!pins.enable_n && pins.load_n))
        else $error("Ripple clock low without enable and load high");

endmodule

`default_nettype wire

// ---- rtl/udcrc_pkg.sv ----
/*
 * Package for the up/down counter with ripple clock.
 * Holds widths, count limits, reset values, direction encoding and
 * the packed struct that carries the sampled pin group.
 * Assumes a single system clock domain for all users.
 */
package udcrc_pkg;

    // Count width and its limits
    localparam int          UDCRC_CNT_W   = 4;
    localparam logic [3:0]  UDCRC_CNT_MAX = 4'hf;
    localparam logic [3:0]  UDCRC_CNT_MIN = 4'h0;
    localparam logic [3:0]  UDCRC_CNT_ONE = 4'h1;

    // Values taken under system reset
    localparam logic [3:0]  UDCRC_CNT_RST  = 4'h0;
    localparam logic        UDCRC_TERM_RST = 1'b0;
    localparam logic        UDCRC_RIPN_RST = 1'b1;
    localparam logic        UDCRC_DIR_RST  = 1'b0;

    // Direction encoding on direction_select
    localparam logic        UDCRC_DIR_UP   = 1'b0;
    localparam logic        UDCRC_DIR_DOWN = 1'b1;

    // Pin inputs sampled as one group
    typedef struct packed {
        logic       clk_lvl;
        logic       load_n;
        logic       enable_n;
        logic       dir;
        logic [3:0] preset;
    } udcrc_pins_t;

    localparam udcrc_pins_t UDCRC_PINS_RST = '{
        clk_lvl:  1'b0,
        load_n:   1'b1,
        enable_n: 1'b1,
        dir:      1'b0,
        preset:   4'h0
    };

endpackage
